// ===== cwp_pkg.sv
/*
 * shared constants for the configuration word decode and write protect block.
 * assumes one clock domain and an asynchronous active-low reset.
 */
package cwp_pkg;

	localparam int CWP_WORD_W = 24;
	localparam int CWP_PAGE_W = 8;

	// register offsets on the plain port
	localparam logic [3:0] CWP_OFF_WORD2 = 4'h0;
	localparam logic [3:0] CWP_OFF_WORD3 = 4'h1;
	localparam logic [3:0] CWP_OFF_LOCK  = 4'h2;
	localparam logic [3:0] CWP_OFF_STAT  = 4'h3;

	// word two field positions
	localparam int CWP_POS_ONEWAY  = 4;
	localparam int CWP_POS_RSV_LO  = 2;
	localparam int CWP_POS_OSC_LO  = 0;

	// word three field positions
	localparam int CWP_POS_ENDPG   = 15;
	localparam int CWP_POS_CFGPROT = 14;
	localparam int CWP_POS_SEGDIS  = 13;
	localparam int CWP_POS_ALT_PARALLEL_PIN_MAP  = 12;
	localparam int CWP_POS_PAGE_LO = 0;
	localparam int CWP_POS_UNIMP   = 16;

	localparam logic [CWP_WORD_W-1:0] CWP_ERASED     = 24'hffffff;
	localparam logic [CWP_WORD_W-1:0] CWP_W3_IMPMASK = 24'h00ffff;

	// unlock key pair written to the lock register
	localparam logic [15:0] CWP_KEY1 = 16'h0046;
	localparam logic [15:0] CWP_KEY2 = 16'h0057;
	localparam logic [15:0] CWP_LOCK_CMD_SET = 16'h0001;
	localparam logic [15:0] CWP_LOCK_CMD_CLR = 16'h0000;

	typedef enum logic [1:0] {
		CWP_OSC_EXT  = 2'b00,
		CWP_OSC_STD  = 2'b01,
		CWP_OSC_HS   = 2'b10,
		CWP_OSC_OFF  = 2'b11
	} cwp_osc_type;

	typedef enum logic [1:0] {
		CWP_UL_IDLE = 2'b00,
		CWP_UL_KEY1 = 2'b01,
		CWP_UL_OPEN = 2'b10
	} cwp_unlock_type;

endpackage

// ===== cwp_cfg_if.sv
/*
 * carries latched configuration fields between the top and its helpers.
 * assumes the top drives all fields from registers.
 */
interface cwp_cfg_if;
	logic                           oneWay;
	logic                           endPage;
	logic                           cfgProtect;
	logic                           segDisable;
	logic [cwp_pkg::CWP_PAGE_W-1:0] boundPage;
	modport src  (output oneWay, endPage, cfgProtect, segDisable, boundPage);
	modport sink (input oneWay, endPage, cfgProtect, segDisable, boundPage);
endinterface

// ===== cwp_prot_check.sv
/*
 * combinational write-protect check for one flash page.
 * assumes the page number and last-page number come from the top.
 */
module cwp_prot_check #(
	parameter int PAGE_W = 8
) (
	cwp_cfg_if.sink          cfg,
	input  wire logic [PAGE_W-1:0] page,
	input  wire logic [PAGE_W-1:0] lastPage,
	output logic             isProt
);
	logic inSeg;
	logic cfgPage;

	// segment membership and config page protection
	always_comb begin
		cfgPage = (page == lastPage);
		if (cfg.endPage)
			inSeg = (page >= cfg.boundPage);
		else
			inSeg = (page <= cfg.boundPage);
		if (cfg.segDisable) begin
			isProt = 1'b0;
		end else if (cfgPage) begin
			isProt = !cfg.cfgProtect || cfg.endPage || (cfg.boundPage == lastPage) || inSeg;
		end else begin
			isProt = inSeg;
		end
	end
endmodule // cwp_prot_check

// ===== cwp_osc_decode.sv
/*
 * decodes the two-bit primary oscillator field into one-hot selects.
 * assumes the field is already latched.
 */
module cwp_osc_decode (
	input  wire logic [1:0] mode,
	output logic            oscOff,
	output logic            oscHs,
	output logic            oscStd,
	output logic            oscExt
);
	// one select per encoding
	always_comb begin
		oscOff = 1'b0;
		oscHs  = 1'b0;
		oscStd = 1'b0;
		oscExt = 1'b0;
		case (cwp_pkg::cwp_osc_type'(mode))
			cwp_pkg::CWP_OSC_OFF: oscOff = 1'b1;
			cwp_pkg::CWP_OSC_HS:  oscHs  = 1'b1;
			cwp_pkg::CWP_OSC_STD: oscStd = 1'b1;
			default:              oscExt = 1'b1;
		endcase
	end
endmodule // cwp_osc_decode

// ===== cwp_config_word_write_protect.sv
/*
 * configuration word store, decode, pin-select lock and flash write gate.
 * assumes a programmer port for one-time word programming and a plain
 * register port for software; all inputs synchronous to core_clk.
 */
// Added by the designer: the strobed register port and the address map.
module cwp_config_word_write_protect #(
	parameter logic [7:0] LAST_PAGE = 8'hff
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// programmer port
	input  wire logic        progWrite,
	input  wire logic        progSel,
	input  wire logic [23:0] progData,
	// software register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [23:0] regRdata,
	// flash write path
	input  wire logic        flashWrReq,
	input  wire logic [7:0]  flashWrPage,
	output logic             flashWrOk,
	output logic             flashWrBlocked,
	// pin-select register write path
	input  wire logic        ppsWrReq,
	output logic             ppsWrOk,
	output logic             pinSelectLock,
	// decoded controls
	output logic             oscOff,
	output logic             oscHs,
	output logic             oscStd,
	output logic             oscExt,
	output logic             pmpDefaultMap
);
	//////////////////////////////////////////////////////////////////////////
	// one-time store: bits can only go from one to zero
	// erased flash content at power-up, never touched by reset
	logic [23:0] word2Reg = cwp_pkg::CWP_ERASED;
	logic [23:0] word3Reg = cwp_pkg::CWP_ERASED;
	logic [23:0] word2Next;
	logic [23:0] word3Next;
	logic        cfgPageProt;

	always_comb begin
		word2Next = word2Reg;
		word3Next = word3Reg;
		if (progWrite && !progSel)
			word2Next = word2Reg & progData;
		else if (progWrite && progSel && !cfgPageProt)
			word3Next = word3Reg & (progData | ~cwp_pkg::CWP_W3_IMPMASK);
	end

	// the store models flash: it survives reset, so it only clears bits
	always_ff @(posedge core_clk) begin
		word2Reg <= word2Next;
		word3Reg <= word3Next;
	end

	//////////////////////////////////////////////////////////////////////////
	// fields latched once per reset release
	logic       latchedReg, latchedNext;
	logic [23:0] lw2Reg, lw2Next;
	logic [23:0] lw3Reg, lw3Next;

	always_comb begin
		latchedNext = 1'b1;
		lw2Next     = latchedReg ? lw2Reg : word2Reg;
		lw3Next     = latchedReg ? lw3Reg : word3Reg;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			latchedReg <= 1'b0;
			lw2Reg     <= cwp_pkg::CWP_ERASED;
			lw3Reg     <= cwp_pkg::CWP_ERASED;
		end else begin
			latchedReg <= latchedNext;
			lw2Reg     <= lw2Next;
			lw3Reg     <= lw3Next;
		end
	end

	cwp_cfg_if cfg();
	assign cfg.oneWay     = lw2Reg[cwp_pkg::CWP_POS_ONEWAY];
	assign cfg.endPage    = lw3Reg[cwp_pkg::CWP_POS_ENDPG];
	assign cfg.cfgProtect = lw3Reg[cwp_pkg::CWP_POS_CFGPROT];
	assign cfg.segDisable = lw3Reg[cwp_pkg::CWP_POS_SEGDIS];
	assign cfg.boundPage  = lw3Reg[cwp_pkg::CWP_POS_PAGE_LO +: cwp_pkg::CWP_PAGE_W];
	assign pmpDefaultMap  = lw3Reg[cwp_pkg::CWP_POS_ALT_PARALLEL_PIN_MAP];

	//////////////////////////////////////////////////////////////////////////
	// protection checks
	logic pageProt;

	cwp_prot_check #(.PAGE_W(cwp_pkg::CWP_PAGE_W)) uPageChk (
		.cfg      (cfg),
		.page     (flashWrPage),
		.lastPage (LAST_PAGE),
		.isProt   (pageProt)
	);

	cwp_prot_check #(.PAGE_W(cwp_pkg::CWP_PAGE_W)) uCfgChk (
		.cfg      (cfg),
		.page     (LAST_PAGE),
		.lastPage (LAST_PAGE),
		.isProt   (cfgPageProt)
	);

	// gate held off until fields are latched, nothing is trusted before
	always_comb begin
		flashWrOk      = flashWrReq && latchedReg && !pageProt;
		flashWrBlocked = flashWrReq && (!latchedReg || pageProt);
	end

	cwp_osc_decode uOsc (
		.mode   (lw2Reg[cwp_pkg::CWP_POS_OSC_LO +: 2]),
		.oscOff (oscOff),
		.oscHs  (oscHs),
		.oscStd (oscStd),
		.oscExt (oscExt)
	);

	//////////////////////////////////////////////////////////////////////////
	// unlock sequence and pin-select lock
	cwp_pkg::cwp_unlock_type ulReg, ulNext;
	logic lockReg, lockNext;
	logic lockUsedReg, lockUsedNext;
	logic lockWr;

	always_comb begin
		lockWr       = regWrite && (regAddr == cwp_pkg::CWP_OFF_LOCK);
		ulNext       = ulReg;
		lockNext     = lockReg;
		lockUsedNext = lockUsedReg;
		case (ulReg)
			cwp_pkg::CWP_UL_IDLE: begin
				if (lockWr && regWdata == cwp_pkg::CWP_KEY1)
					ulNext = cwp_pkg::CWP_UL_KEY1;
			end
			cwp_pkg::CWP_UL_KEY1: begin
				if (lockWr && regWdata == cwp_pkg::CWP_KEY2)
					ulNext = cwp_pkg::CWP_UL_OPEN;
				else if (lockWr)
					ulNext = cwp_pkg::CWP_UL_IDLE;
			end
			cwp_pkg::CWP_UL_OPEN: begin
				if (lockWr) begin
					ulNext = cwp_pkg::CWP_UL_IDLE;
					if (regWdata == cwp_pkg::CWP_LOCK_CMD_SET) begin
						if (!(cfg.oneWay && lockUsedReg)) begin
							lockNext     = 1'b1;
							lockUsedNext = 1'b1;
						end
					end else if (regWdata == cwp_pkg::CWP_LOCK_CMD_CLR) begin
						if (!cfg.oneWay)
							lockNext = 1'b0;
					end
				end
			end
			default: ulNext = cwp_pkg::CWP_UL_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ulReg       <= cwp_pkg::CWP_UL_IDLE;
			lockReg     <= 1'b0;
			lockUsedReg <= 1'b0;
		end else begin
			ulReg       <= ulNext;
			lockReg     <= lockNext;
			lockUsedReg <= lockUsedNext;
		end
	end

	assign pinSelectLock = lockReg;
	assign ppsWrOk       = ppsWrReq && !lockReg;

	//////////////////////////////////////////////////////////////////////////
	// register read port, data one cycle after the strobe
	logic [23:0] rdReg, rdNext;

	always_comb begin
		rdNext = 24'h000000;
		if (regRead) begin
			if (regAddr == cwp_pkg::CWP_OFF_WORD2)
				rdNext = lw2Reg;
			else if (regAddr == cwp_pkg::CWP_OFF_WORD3)
				rdNext = lw3Reg | ~cwp_pkg::CWP_W3_IMPMASK;
			else if (regAddr == cwp_pkg::CWP_OFF_LOCK)
				rdNext = {22'h000000, lockUsedReg, lockReg};
			else if (regAddr == cwp_pkg::CWP_OFF_STAT)
				rdNext = {21'h000000, cfgPageProt, ulReg};
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rdReg <= 24'h000000;
		else
			rdReg <= rdNext;
	end

	assign regRdata = rdReg;
endmodule // cwp_config_word_write_protect

// ===== cwp_chk.sv
/* assertions on the config word block ports.
   assumes one core_clk domain and the bind below. */
module cwp_chk (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [23:0] regRdata,
	input wire logic        flashWrReq,
	input wire logic        flashWrOk,
	input wire logic        flashWrBlocked,
	input wire logic        ppsWrReq,
	input wire logic        ppsWrOk,
	input wire logic        pinSelectLock,
	input wire logic        oscOff,
	input wire logic        oscHs,
	input wire logic        oscStd,
	input wire logic        oscExt,
	input wire logic        pmpDefaultMap
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// lock writes and the full unlock-then-set walk
	sequence lockWr(v);
		regWrite && regAddr == cwp_pkg::CWP_OFF_LOCK && regWdata == v;
	endsequence
	sequence setSeq;
		lockWr(cwp_pkg::CWP_KEY1) ##1 lockWr(cwp_pkg::CWP_KEY2)
			##1 lockWr(cwp_pkg::CWP_LOCK_CMD_SET);
	endsequence
	lock_set_a: assert property (setSeq |=> pinSelectLock)
		else $error("lock not set after unlock");
	lock_rise_a: assert property ($rose(pinSelectLock) |-> $past(regWrite) &&
		$past(regWdata) == cwp_pkg::CWP_LOCK_CMD_SET) else $error("lock rose unasked");
	lock_fall_a: assert property ($fell(pinSelectLock) |-> $past(regWrite) &&
		$past(regWdata) == cwp_pkg::CWP_LOCK_CMD_CLR) else $error("lock fell unasked");
	// latch lands at first edge, so compare from the third
	ctrl_stable_a: assert property ($past(rstn, 2) |->
		$stable({oscOff, oscHs, oscStd, oscExt, pmpDefaultMap})) else $error("controls moved");
	pps_gate_a: assert property (ppsWrOk == (ppsWrReq && !pinSelectLock))
		else $error("pin-select gate wrong");
	flash_gate_a: assert property ((flashWrOk || flashWrBlocked) == flashWrReq
		&& !(flashWrOk && flashWrBlocked)) else $error("flash answer wrong");
	osc_onehot_a: assert property ($onehot({oscOff, oscHs, oscStd, oscExt}))
		else $error("oscillator select not one-hot");
	unimp_ones_a: assert property (regRead && regAddr == cwp_pkg::CWP_OFF_WORD3
		|=> regRdata[23:16] == 8'hff) else $error("upper bits not ones");
endmodule // cwp_chk
////////////////////////////////////////
bind cwp_config_word_write_protect cwp_chk chk (.*);

// ===== cwp_prog_model.sv
/* programmer model for the one-time words.
   assumes burn() is called just after a rising edge. */
module cwp_prog_model (
	input  wire logic   core_clk,
	output logic        progWrite,
	output logic        progSel,
	output logic [23:0] progData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		progWrite = 1'b0;
		progSel = 1'b0;
		progData = 24'h000000;
	end
	// one strobe; data inverted after so stale values never match
	task automatic burn(input logic sel, input logic [23:0] data);
		progSel <= sel;
		progData <= sel ? data : data | 24'h00000c;
		progWrite <= 1'b1;
		@(posedge core_clk);
		progWrite <= 1'b0;
		progData <= ~data;
		@(posedge core_clk);
	endtask
endmodule // cwp_prog_model

// ===== cwp_tb.sv
/* self-checking bench for the config word block.
   assumes the programmer model and the checker bind. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        flashWrReq = 1'b0;
	logic [7:0]  flashWrPage = 8'h00;
	logic        ppsWrReq = 1'b1;
	logic        progWrite, progSel, ppsWrOk, pinSelectLock, flashWrOk, flashWrBlocked;
	logic        oscOff, oscHs, oscStd, oscExt, pmpDefaultMap;
	logic [23:0] progData, regRdata;
	logic [23:0] rdQ[$];
	logic        rdPend = 1'b0;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;
	always #5 core_clk = ~core_clk;
	cwp_prog_model prog (.*);
	cwp_config_word_write_protect uut (.*);
	////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic chkWord(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: read %h not %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [23:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		rdQ.push_back(e);
		@(posedge core_clk);
		regRead <= 1'b0;
		@(posedge core_clk);
	endtask
	// key, key, command back to back on the lock offset
	task automatic lockSeq(input logic [15:0] k1, input logic [15:0] cmd);
		logic [15:0] keys[3];
		keys = '{k1, cwp_pkg::CWP_KEY2, cmd};
		foreach (keys[i]) begin
			regAddr <= cwp_pkg::CWP_OFF_LOCK;
			regWdata <= keys[i];
			regWrite <= 1'b1;
			@(posedge core_clk);
		end
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic fl(input logic [7:0] p, input logic ok);
		flashWrReq <= 1'b1;
		flashWrPage <= p;
		#1;
		chk(flashWrOk, ok);
		chk(flashWrBlocked, !ok);
		@(posedge core_clk);
	endtask
	task automatic doReset;
		rstn <= 1'b0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	// read data stands one cycle after the strobe
	always @(posedge core_clk) begin
		if (rdPend) chkWord(regRdata, rdQ.pop_front());
		rdPend <= regRead;
	end
	// hang limit, run needs under a hundred cycles
	always @(posedge core_clk) if (++cycles == 1000) begin
		fails++;
		test_done();
	end
	initial begin
		void'($urandom(32'h04ca));
		doReset();
		// erased words leave everything open
		rd(cwp_pkg::CWP_OFF_WORD2, 24'hffffff);
		rd(cwp_pkg::CWP_OFF_WORD3, 24'hffffff);
		chk(oscOff, 1'b1);
		chk(pmpDefaultMap, 1'b1);
		fl(8'($urandom), 1'b1);
		prog.burn(1'b0, 24'hfffffe);
		prog.burn(1'b1, 24'hff4f10);
		// fields read back stay latched until the next reset
		rd(cwp_pkg::CWP_OFF_WORD3, 24'hffffff);
		doReset();
		rd(cwp_pkg::CWP_OFF_WORD3, 24'hff4f10);
		// one-way lock, low segment up to page 16
		chk(oscHs, 1'b1);
		chk(pmpDefaultMap, 1'b0);
		fl(8'($urandom_range(15, 0)), 1'b0);
		fl(8'($urandom_range(254, 32)), 1'b1);
		fl(8'hff, 1'b1);
		lockSeq(cwp_pkg::CWP_KEY1, cwp_pkg::CWP_LOCK_CMD_SET);
		chk(ppsWrOk, 1'b0);
		lockSeq(cwp_pkg::CWP_KEY1, cwp_pkg::CWP_LOCK_CMD_CLR);
		chk(pinSelectLock, 1'b1);
		prog.burn(1'b0, 24'hffffec);
		prog.burn(1'b1, 24'hff0f10);
		doReset();
		// lock toggles freely, last page now guarded
		chk(oscExt, 1'b1);
		fl(8'hff, 1'b0);
		flashWrReq <= 1'b0;
		lockSeq(cwp_pkg::CWP_KEY1, cwp_pkg::CWP_LOCK_CMD_SET);
		chk(pinSelectLock, 1'b1);
		lockSeq(cwp_pkg::CWP_KEY1, cwp_pkg::CWP_LOCK_CMD_CLR);
		chk(ppsWrOk, 1'b1);
		lockSeq(16'h0100 | 16'($urandom_range(255, 0)), cwp_pkg::CWP_LOCK_CMD_SET);
		chk(pinSelectLock, 1'b0);
		// guarded config page refuses the burn, seen after reset
		prog.burn(1'b1, 24'hff0f00);
		doReset();
		rd(cwp_pkg::CWP_OFF_WORD3, 24'hff0f10);
		test_done();
	end
endmodule // tb
